// *** verif/core_osc_model.sv ***
// model: core and main oscillator beside the clock controller
`timescale 1ns/1ps
module core_osc_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // bench commands
  input  wire logic sleepCmd,
  input  wire logic wakeCmd,
  // from controller
  input  wire logic coreClkEn,
  input  wire logic mainOscPowerDown,
  // to controller
  output logic      waitForInterrupt,
  output logic      irqPending,
  output logic      mainOscTick
);
  initial mainOscTick = 1'b0;
  // oscillator runs only while powered
  always #6 mainOscTick = mainOscPowerDown ? 1'b0 : ~mainOscTick;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      waitForInterrupt <= 1'b0;
      irqPending       <= 1'b0;
    end
    else
    begin
      irqPending <= wakeCmd;
      if (sleepCmd)
        waitForInterrupt <= 1'b1;
      else if (irqPending && coreClkEn)
        waitForInterrupt <= 1'b0;
    end
  end
endmodule // core_osc_model

// *** verif/sysclk_ctrl_chk.sv ***
// checker: port-level properties of the clock controller
`timescale 1ns/1ps
module sysclk_ctrl_chk
  import sysclk_ctrl_pkg::*;
#(
  parameter int NGATE = 32
) (
  // clock, reset, bus
  input wire logic             ref_clk,
  input wire logic             rst,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  // core and wake
  input wire logic             waitForInterrupt,
  input wire logic             hibWake,
  input wire logic             rtcWake,
  input wire logic             hibPowerOn,
  // clock controls
  input wire logic [2:0]       sysClkSrc,
  input wire logic             pllPowerDown,
  input wire logic             pllOutEnable,
  input wire logic             coreClkEn,
  input wire logic [NGATE-1:0] periphClkEn,
  input wire logic [15:0]      pllTranslation
);
  logic rccWr;
  assign rccWr = psel && penable && pwrite && paddr == OFS_RCC;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rst_src;
    $fell(rst) |-> sysClkSrc == SRC_INT;
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("source after reset");
  property p_rst_pll;
    $fell(rst) |-> pllPowerDown && !pllOutEnable;
  endproperty
  a_rst_pll: assert property (p_rst_pll) else $error("pll up after reset");
  property p_rst_gate;
    $fell(rst) |-> periphClkEn == GATE0_RST[NGATE-1:0] && coreClkEn;
  endproperty
  a_rst_gate: assert property (p_rst_gate) else $error("gates after reset");
  property p_pll_out;
    pllPowerDown |-> !pllOutEnable;
  endproperty
  a_pll_out: assert property (p_pll_out) else $error("pll drives while down");
  property p_pll_sel;
    $rose(sysClkSrc == SRC_PLL) |-> !pllPowerDown && pllOutEnable;
  endproperty
  a_pll_sel: assert property (p_pll_sel) else $error("pll chosen while off");
  property p_src_hold;
    !$stable(sysClkSrc) |=> $stable(sysClkSrc)[*3];
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("source switched too fast");
  property p_xlat;
    !$stable(pllTranslation) |-> $past(rccWr) || $past(rccWr, 2);
  endproperty
  a_xlat: assert property (p_xlat) else $error("translation changed unasked");
  property p_hib;
    !$past(rst) |-> hibPowerOn == ($past(hibWake) || $past(rtcWake));
  endproperty
  a_hib: assert property (p_hib) else $error("hibernate wake wrong");
  property p_slp_req;
    $fell(coreClkEn) |-> waitForInterrupt || $past(waitForInterrupt);
  endproperty
  a_slp_req: assert property (p_slp_req) else $error("sleep without request");
endmodule // sysclk_ctrl_chk

bind system_clock_and_sleep_control sysclk_ctrl_chk #(.NGATE(NGATE)) chk_u (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .waitForInterrupt(waitForInterrupt), .hibWake(hibWake),
  .rtcWake(rtcWake), .hibPowerOn(hibPowerOn), .sysClkSrc(sysClkSrc),
  .pllPowerDown(pllPowerDown), .pllOutEnable(pllOutEnable), .coreClkEn(coreClkEn),
  .periphClkEn(periphClkEn), .pllTranslation(pllTranslation)
);

// *** verif/tb_top.sv ***
// testbench: registers, relock and sleep modes of the clock controller
`timescale 1ns/1ps
module tb_top;
  import sysclk_ctrl_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        hibWake = 1'b0;
  logic        rtcWake = 1'b0;
  logic        sleepCmd = 1'b0;
  logic        wakeCmd = 1'b0;
  logic        pready, pslverr, mainOscTick, waitForInterrupt, irqPending, hibPowerOn;
  logic        useDivider, pllPowerDown, pllOutEnable, mainOscPowerDown, coreClkEn;
  logic [31:0] prdata, periphClkEn, rv, r2, run_clock_cfg;
  logic [2:0]  sysClkSrc;
  logic [5:0]  sysDivider;
  logic [15:0] pllTranslation, x0;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #2.5 ref_clk = ~ref_clk;

  system_clock_and_sleep_control dut_u (
    .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .mainOscTick, .waitForInterrupt, .irqPending, .hibWake, .rtcWake,
    .hibPowerOn, .sysClkSrc, .sysDivider, .useDivider, .pllPowerDown, .pllOutEnable,
    .mainOscPowerDown, .coreClkEn, .periphClkEn, .pllTranslation
  );
  core_osc_model core_u (
    .ref_clk, .rst, .sleepCmd, .wakeCmd, .coreClkEn, .mainOscPowerDown,
    .waitForInterrupt, .irqPending, .mainOscTick
  );

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  function automatic logic [31:0] probe(input int s);
    return s == 0 ? 32'(sysClkSrc) : 32'(coreClkEn);
  endfunction

  task automatic waitfor(input string nm, input int s, input logic [31:0] e, input int lim);
    int n;
    n = 0;
    while (probe(s) !== e && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(nm, e, probe(s));
  endtask

  task automatic t_reset;
    logic [11:0] a[6] = '{OFS_RCC, OFS_RCC_EXT, OFS_RUNGATE, OFS_SLPGATE, OFS_DSLGATE,
                          OFS_DSLCFG};
    logic [31:0] e[6] = '{RCC_RST, RCC_EXT_RST, GATE0_RST, GATE0_RST, GATE0_RST,
                          DSLCFG_RST};
    chk("rstSrc", 32'(SRC_INT), 32'(sysClkSrc));
    chk("rstPd", 32'h1, 32'(pllPowerDown));
    chk("rstMosc", 32'h1, 32'(mainOscPowerDown));
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, a[i], 32'h0, rv);
      chk("regReset", e[i], rv);
    end
    apb(1'b1, 12'h0FC, 32'hFFFFFFFF, rv);
    apb(1'b0, 12'h0FC, 32'h0, rv);
    chk("unmapped", 32'h0, rv);
    chk("slvErr", 32'h0, 32'(pslverr));
    $display("t_reset done");
  endtask

  task automatic t_src;
    logic [2:0] s[5] = '{SRC_MAIN, SRC_INT, SRC_INT4, SRC_INT30K, SRC_RTC};
    run_clock_cfg = RCC_RST;
    run_clock_cfg[MAIN_OSC_DIS_BIT] = 1'b0;
    run_clock_cfg[OSCSRC_LSB+:2] = 2'b00;
    apb(1'b1, OFS_RCC, run_clock_cfg, rv);
    repeat (100) @(posedge ref_clk);
    chk("moscOn", 32'h0, 32'(mainOscPowerDown));
    foreach (s[i])
    begin
      apb(1'b1, OFS_RCC_EXT, RCC_EXT_RST | 32'h80000000 | (32'(s[i]) << EXT_SRC_LSB), rv);
      waitfor("extSrc", 0, 32'(s[i]), 40);
    end
    apb(1'b1, OFS_RCC_EXT, RCC_EXT_RST, rv);
    waitfor("baseSrc", 0, 32'(SRC_MAIN), 40);
    $display("t_src done");
  endtask

  task automatic t_pll;
    int n;
    int t0;
    x0 = pllTranslation;
    run_clock_cfg[CRYSTAL_SELECT_LSB+:CRYSTAL_SELECT_W] = 4'hE;
    run_clock_cfg[PWRDN_BIT] = 1'b0;
    run_clock_cfg[BYPASS_BIT] = 1'b0;
    run_clock_cfg[USESYS_BIT] = 1'b1;
    apb(1'b1, OFS_RCC, run_clock_cfg, rv);
    t0 = cyc;
    repeat (3) @(posedge ref_clk);
    chk("xlatNew", 32'h1, 32'(pllTranslation !== x0));
    chk("pllPd", 32'h0, 32'(pllPowerDown));
    chk("useSys", 32'h1, 32'(useDivider));
    apb(1'b0, OFS_PLLXLAT, 32'h0, r2);
    apb(1'b1, OFS_PLLXLAT, 32'hFFFFFFFF, rv);
    apb(1'b0, OFS_PLLXLAT, 32'h0, rv);
    chk("xlatRo", r2, rv);
    chk("pllBlocked", 32'h1, 32'(sysClkSrc !== SRC_PLL));
    n = 0;
    do
    begin
      apb(1'b0, OFS_STATUS, 32'h0, rv);
      n++;
    end
    while (rv[6] !== 1'b1 && n < 6000);
    chk("relockTime", 32'h1, 32'(cyc - t0 > 10900 && cyc - t0 < 11300));
    waitfor("pllSel", 0, 32'(SRC_PLL), 20);
    chk("pllOut", 32'h1, 32'(pllOutEnable));
    apb(1'b1, OFS_RCC, run_clock_cfg, rv);
    repeat (20) @(posedge ref_clk);
    chk("sameXtal", 32'(SRC_PLL), 32'(sysClkSrc));
    apb(1'b1, OFS_RUNGATE, 32'h000000FF, rv);
    apb(1'b1, OFS_SLPGATE, 32'h0000000F, rv);
    apb(1'b1, OFS_DSLGATE, 32'h00000003, rv);
    $display("t_pll done");
  endtask

  task automatic t_sleep(input logic ag, input logic deep);
    logic [5:0] dv;
    int t0;
    run_clock_cfg[AUTOGATE_BIT] = ag;
    apb(1'b1, OFS_RCC, run_clock_cfg, rv);
    apb(1'b1, OFS_MODE, {31'h0, deep}, rv);
    dv = sysDivider;
    sleepCmd <= 1'b1;
    @(posedge ref_clk);
    sleepCmd <= 1'b0;
    waitfor("coreOff", 1, 32'h0, 40);
    waitfor("slpSrc", 0, 32'(deep ? SRC_MAIN : SRC_PLL), 40);
    chk("slpGate", ag ? (deep ? 32'h3 : 32'hF) : 32'hFF, periphClkEn);
    chk("slpPd", 32'(deep), 32'(pllPowerDown));
    chk("slpDiv", 32'(deep ? DSL_DIV16 : dv), 32'(sysDivider));
    wakeCmd <= 1'b1;
    t0 = cyc;
    waitfor("coreOn", 1, 32'h1, 20000);
    chk("wakeRelock", 32'(deep), 32'(cyc - t0 > 10900));
    chk("wakeSrc", 32'(SRC_PLL), 32'(sysClkSrc));
    @(posedge ref_clk);
    chk("runGate", 32'hFF, periphClkEn);
    wakeCmd <= 1'b0;
    repeat (2) @(posedge ref_clk);
    $display("t_sleep %0d %0d done", ag, deep);
  endtask

  task automatic t_hib;
    for (int i = 1; i < 3; i++)
    begin
      {rtcWake, hibWake} <= 2'(i);
      @(posedge ref_clk);
      {rtcWake, hibWake} <= 2'b00;
      @(posedge ref_clk);
      chk("hibOn", 32'h1, 32'(hibPowerOn));
      @(posedge ref_clk);
      chk("hibOff", 32'h0, 32'(hibPowerOn));
    end
    $display("t_hib done");
  endtask

  task automatic t_relock;
    run_clock_cfg[CRYSTAL_SELECT_LSB+:CRYSTAL_SELECT_W] = 4'hD;
    apb(1'b1, OFS_RCC, run_clock_cfg, rv);
    repeat (20) @(posedge ref_clk);
    chk("xtalRelock", 32'h1, 32'(sysClkSrc !== SRC_PLL));
    $display("t_relock done");
  endtask

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_src();
    t_pll();
    t_sleep(1'b0, 1'b0);
    t_sleep(1'b1, 1'b0);
    t_sleep(1'b1, 1'b1);
    t_hib();
    t_relock();
    test_done();
  end
endmodule // tb_top

// *** verilog/sysclk_ctrl_pkg.sv ***
// package: register map, field layout and timing constants of the clock controller
package sysclk_ctrl_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_STATUS   = 12'h050;
  localparam logic [11:0] OFS_RCC      = 12'h060;
  localparam logic [11:0] OFS_PLLXLAT  = 12'h064;
  localparam logic [11:0] OFS_RCC_EXT  = 12'h070;
  localparam logic [11:0] OFS_RUNGATE  = 12'h100;
  localparam logic [11:0] OFS_SLPGATE  = 12'h110;
  localparam logic [11:0] OFS_DSLGATE  = 12'h120;
  localparam logic [11:0] OFS_DSLCFG   = 12'h144;
  localparam logic [11:0] OFS_MODE     = 12'h148;
  // reset values
  localparam logic [31:0] RCC_RST      = 32'h07A03AD1;
  localparam logic [31:0] RCC_EXT_RST  = 32'h07802800;
  localparam logic [31:0] GATE0_RST    = 32'h00000040;
  localparam logic [31:0] DSLCFG_RST   = 32'h07800000;
  // run_clock_cfg fields
  localparam int MAIN_OSC_DIS_BIT = 0;
  localparam int OSCSRC_LSB   = 4;
  localparam int CRYSTAL_SELECT_LSB     = 6;
  localparam int CRYSTAL_SELECT_W       = 4;
  localparam int BYPASS_BIT   = 11;
  localparam int PWRDN_BIT    = 13;
  localparam int USESYS_BIT   = 22;
  localparam int SYSTEM_DIVIDER_LSB   = 23;
  localparam int SYSTEM_DIVIDER_W     = 4;
  localparam int AUTOGATE_BIT = 27;
  // run_clock_cfg_ext fields
  localparam int EXT_SRC_LSB    = 4;
  localparam int EXT_SRC_W      = 3;
  localparam int EXT_BYPASS_BIT = 11;
  localparam int EXT_PWRDN_BIT  = 13;
  localparam int EXT_DIV_LSB    = 23;
  localparam int EXT_DIV_W      = 6;
  localparam int EXT_SEL_BIT    = 31;
  // deepsleep_clock_cfg source field
  localparam int DSL_SRC_LSB = 4;
  // mode register: bit0 deep-sleep enable
  localparam int DEEPEN_BIT = 0;
  // source select codes (sysclk mux)
  localparam logic [2:0] SRC_MAIN   = 3'h0;
  localparam logic [2:0] SRC_INT    = 3'h1;
  localparam logic [2:0] SRC_INT4   = 3'h2;
  localparam logic [2:0] SRC_INT30K = 3'h3;
  localparam logic [2:0] SRC_RTC    = 3'h7;
  localparam logic [2:0] SRC_PLL    = 3'h4;
  // deep-sleep divider overrides
  localparam logic [5:0] DSL_DIV16 = 6'h0F;
  localparam logic [5:0] DSL_DIV64 = 6'h3F;
  // relock count
  localparam logic [12:0] RELOCK_LOAD = 13'h1200;
  // power states
  typedef enum logic [1:0] {
    PM_RUN   = 2'b00,
    PM_SLEEP = 2'b01,
    PM_DEEP  = 2'b11,
    PM_RESTORE = 2'b10
  } pmode_t;
endpackage

// *** verilog/system_clock_and_sleep_control.sv ***
// module: system clock selection, pll relock, peripheral gating and sleep control
//
// Operation
// - reset selects internal oscillator as sysclk
// - six selectable sysclk sources
// - extended config overrides base fields
// - crystal change updates read-only translation
// - pll disabled after reset
// - pll normal drives output, powerdown not
// - relock on crystal change or powerup
// - main-osc down counter loaded 0x1200
// - pll selection blocked until relock done
// - run, sleep, deep-sleep gate sets
// - sleep stops core, uses sleep gates
// - sleep keeps run clock source
// - deep-sleep stops core, uses deep gates
// - deep enable then wfi enters deep-sleep
// - interrupt wakes to run mode
// - deep-sleep source main osc or internal
// - deep-sleep powers pll down, divides when pll was source
// - restore clock before re-enabling gates
// - hibernate wake by external or rtc
`timescale 1ns/1ps
module system_clock_and_sleep_control
  import sysclk_ctrl_pkg::*;
#(
  parameter int NGATE = 32,
  parameter int SWITCH_WAIT = 4
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  // main oscillator tick (asynchronous)
  input  wire logic             mainOscTick,
  // core requests and wake events
  input  wire logic             waitForInterrupt,
  input  wire logic             irqPending,
  input  wire logic             hibWake,
  input  wire logic             rtcWake,
  output logic                  hibPowerOn,
  // clock controls
  output logic [2:0]            sysClkSrc,
  output logic [5:0]            sysDivider,
  output logic                  useDivider,
  output logic                  pllPowerDown,
  output logic                  pllOutEnable,
  output logic                  mainOscPowerDown,
  output logic                  coreClkEn,
  output logic [NGATE-1:0]      periphClkEn,
  output logic [15:0]           pllTranslation
);

  // register state
  logic [31:0]      rcc_q;
  logic [31:0]      rccExt_q;
  logic [31:0]      dslCfg_q;
  logic             deepEn_q;
  logic [NGATE-1:0] runGate_q;
  logic [NGATE-1:0] slpGate_q;
  logic [NGATE-1:0] dslGate_q;
  logic [CRYSTAL_SELECT_W-1:0] xtalPrev_q;
  logic             pwrdnPrev_q;
  pmode_t           mode_q;
  logic [2:0]       srcSave_q;
  logic [5:0]       divSave_q;
  logic [12:0]      relockCnt_q;
  logic             relockReq_q;
  logic             relockAck_q;
  logic             lockRaw_q;
  logic [2:0]       tickSync_q;
  logic [2:0]       curSrc_q;
  logic [3:0]       swCnt_q;

  // gate vector widened to a 32-bit register word
  function automatic logic [31:0] gateWord(input logic [NGATE-1:0] g);
    logic [31:0] w;
    w = '0;
    w[NGATE-1:0] = g;
    return w;
  endfunction

  // crystal number to pll codes: divider in low bits, feedback above
  function automatic logic [15:0] xtalXlat(input logic [CRYSTAL_SELECT_W-1:0] x);
    logic [15:0] t;
    t = {4'h0, 8'(8'h40 - {4'h0, x}), x};
    return t;
  endfunction

  logic       useExt;
  logic [2:0] effSrc;
  logic       effBypass;
  logic       effPwrdn;
  logic [5:0] effDiv;
  logic       autoGate;
  logic [2:0] wantSrc;
  logic       apbWr;
  logic       xtalChange;
  logic       pllStart;
  logic       pllDown;

  assign useExt    = rccExt_q[EXT_SEL_BIT];
  always_comb
  begin
    if (useExt)
    begin
      effSrc    = rccExt_q[EXT_SRC_LSB +: EXT_SRC_W];
      effBypass = rccExt_q[EXT_BYPASS_BIT];
      effPwrdn  = rccExt_q[EXT_PWRDN_BIT];
      effDiv    = rccExt_q[EXT_DIV_LSB +: EXT_DIV_W];
    end
    else
    begin
      effSrc    = {1'b0, rcc_q[OSCSRC_LSB +: 2]};
      effBypass = rcc_q[BYPASS_BIT];
      effPwrdn  = rcc_q[PWRDN_BIT];
      effDiv    = {2'b00, rcc_q[SYSTEM_DIVIDER_LSB +: SYSTEM_DIVIDER_W]};
    end
  end
  assign autoGate = rcc_q[AUTOGATE_BIT];
  assign apbWr    = psel && penable && pwrite;

  // apb write side
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rcc_q     <= RCC_RST;
      rccExt_q  <= RCC_EXT_RST;
      dslCfg_q  <= DSLCFG_RST;
      deepEn_q  <= 1'b0;
      runGate_q <= NGATE'(GATE0_RST);
      slpGate_q <= NGATE'(GATE0_RST);
      dslGate_q <= NGATE'(GATE0_RST);
    end
    else if (apbWr)
    begin
      case (paddr)
        OFS_RCC:     rcc_q     <= pwdata;
        OFS_RCC_EXT: rccExt_q  <= pwdata;
        OFS_DSLCFG:  dslCfg_q  <= pwdata;
        OFS_MODE:    deepEn_q  <= pwdata[DEEPEN_BIT];
        OFS_RUNGATE: runGate_q <= pwdata[NGATE-1:0];
        OFS_SLPGATE: slpGate_q <= pwdata[NGATE-1:0];
        OFS_DSLGATE: dslGate_q <= pwdata[NGATE-1:0];
        default:     ;
      endcase
    end
  end

  // apb read side, zero wait
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      // captured in setup, stable through the access phase
      case (paddr)
        OFS_STATUS:  prdata <= {25'h0000000, lockRaw_q, 6'h00};
        OFS_RCC:     prdata <= rcc_q;
        OFS_PLLXLAT: prdata <= {16'h0000, pllTranslation};
        OFS_RCC_EXT: prdata <= rccExt_q;
        OFS_DSLCFG:  prdata <= dslCfg_q;
        OFS_MODE:    prdata <= {28'h0000000, mode_q, 1'b0, deepEn_q};
        OFS_RUNGATE: prdata <= gateWord(runGate_q);
        OFS_SLPGATE: prdata <= gateWord(slpGate_q);
        OFS_DSLGATE: prdata <= gateWord(dslGate_q);
        default:     prdata <= 32'h00000000;
      endcase
    end
  end

  // crystal translation table
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      xtalPrev_q     <= RCC_RST[CRYSTAL_SELECT_LSB +: CRYSTAL_SELECT_W];
      pllTranslation <= xtalXlat(RCC_RST[CRYSTAL_SELECT_LSB +: CRYSTAL_SELECT_W]);
      pwrdnPrev_q    <= 1'b1;
    end
    else
    begin
      xtalPrev_q     <= rcc_q[CRYSTAL_SELECT_LSB +: CRYSTAL_SELECT_W];
      pwrdnPrev_q    <= pllDown;
      pllTranslation <= xtalXlat(rcc_q[CRYSTAL_SELECT_LSB +: CRYSTAL_SELECT_W]);
    end
  end
  // pll down by software or by deep-sleep; a wake counts as power-up
  assign pllDown    = effPwrdn || mode_q == PM_DEEP;
  assign xtalChange = rcc_q[CRYSTAL_SELECT_LSB +: CRYSTAL_SELECT_W] != xtalPrev_q;
  assign pllStart   = xtalChange || (pwrdnPrev_q && !pllDown);

  // relock request level held until the relock counter acknowledges the load
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      relockReq_q <= 1'b0;
    else if (pllStart)
      relockReq_q <= 1'b1;
    else if (relockAck_q)
      relockReq_q <= 1'b0;
  end

  // main oscillator edge detect after two-stage sync
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      tickSync_q <= 3'b000;
    else
      tickSync_q <= {tickSync_q[1:0], mainOscTick};
  end

  // relock down counter on main osc ticks
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      relockCnt_q <= 13'h0000;
      lockRaw_q   <= 1'b0;
      relockAck_q <= 1'b0;
    end
    else if (relockReq_q)
    begin
      relockCnt_q <= RELOCK_LOAD;
      lockRaw_q   <= 1'b0;
      relockAck_q <= 1'b1;
    end
    else
    begin
      relockAck_q <= 1'b0;
      if (tickSync_q[1] && !tickSync_q[2] && relockCnt_q != 13'h0000)
        relockCnt_q <= relockCnt_q - 13'h0001;
      // a trigger drops lock at once so the mux never takes an unsettled pll
      if (pllDown || pllStart)
        lockRaw_q <= 1'b0;
      else if (relockCnt_q == 13'h0000)
        lockRaw_q <= 1'b1;
    end
  end

  // power mode sequencing
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode_q    <= PM_RUN;
      srcSave_q <= SRC_INT;
      divSave_q <= 6'h00;
    end
    else
    begin
      case (mode_q)
        PM_RUN:
          if (waitForInterrupt && !irqPending)
          begin
            srcSave_q <= curSrc_q;
            divSave_q <= effDiv;
            mode_q    <= deepEn_q ? PM_DEEP : PM_SLEEP;
          end
        PM_SLEEP:
          if (irqPending)
            mode_q <= PM_RUN;
        PM_DEEP:
          if (irqPending)
            mode_q <= PM_RESTORE;
        PM_RESTORE:
          if (curSrc_q == srcSave_q && swCnt_q == 4'h0)
            mode_q <= PM_RUN;
        default:
          mode_q <= PM_RUN;
      endcase
    end
  end

  // target source
  logic pllRunning;
  assign pllRunning = !effPwrdn && !effBypass;
  always_comb
  begin
    if (mode_q == PM_DEEP)
      wantSrc = (dslCfg_q[DSL_SRC_LSB +: 3] == SRC_INT ||
                 dslCfg_q[DSL_SRC_LSB +: 3] == SRC_INT30K) ?
                dslCfg_q[DSL_SRC_LSB +: 3] : SRC_MAIN;
    else if (mode_q == PM_RESTORE)
      // wake waits for relock when the pll was the source
      wantSrc = (srcSave_q == SRC_PLL && !lockRaw_q) ? curSrc_q : srcSave_q;
    else if (pllRunning && lockRaw_q)
      wantSrc = SRC_PLL;
    else if (pllRunning)
      wantSrc = curSrc_q == SRC_PLL ? SRC_MAIN : curSrc_q;
    else
      wantSrc = effSrc;
  end

  // source switch with dead interval, old select kept on the output until it ends
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      curSrc_q <= SRC_INT;
      swCnt_q  <= 4'h0;
    end
    else if (swCnt_q != 4'h0)
      swCnt_q <= swCnt_q - 4'h1;
    else if (wantSrc != curSrc_q)
    begin
      curSrc_q <= wantSrc;
      swCnt_q  <= 4'(SWITCH_WAIT);
    end
  end

  // clock outputs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sysClkSrc        <= SRC_INT;
      sysDivider       <= 6'h00;
      useDivider       <= 1'b0;
      pllPowerDown     <= 1'b1;
      pllOutEnable     <= 1'b0;
      mainOscPowerDown <= 1'b1;
      coreClkEn        <= 1'b1;
      periphClkEn      <= NGATE'(GATE0_RST);
      hibPowerOn       <= 1'b0;
    end
    else
    begin
      // old select held while the dead interval runs
      sysClkSrc    <= swCnt_q != 4'h0 ? sysClkSrc : curSrc_q;
      hibPowerOn   <= hibWake || rtcWake;
      pllPowerDown <= pllDown;
      pllOutEnable <= !pllDown;
      if (mode_q == PM_DEEP && srcSave_q == SRC_PLL)
        sysDivider <= (effDiv > 6'h0F) ? DSL_DIV64 : DSL_DIV16;
      else if (mode_q == PM_RESTORE)
        sysDivider <= divSave_q;
      else
        sysDivider <= effDiv;
      useDivider   <= rcc_q[USESYS_BIT];
      mainOscPowerDown <= rcc_q[MAIN_OSC_DIS_BIT] ||
                          (mode_q == PM_DEEP && wantSrc != SRC_MAIN);
      coreClkEn    <= mode_q == PM_RUN;
      case (mode_q)
        PM_SLEEP:   periphClkEn <= autoGate ? slpGate_q : runGate_q;
        PM_DEEP:    periphClkEn <= autoGate ? dslGate_q : runGate_q;
        PM_RESTORE: periphClkEn <= autoGate ? dslGate_q : runGate_q;
        default:    periphClkEn <= runGate_q;
      endcase
    end
  end

endmodule // system_clock_and_sleep_control
